// >>> core/mic_pkg.sv
// Constants, field layouts and carrier types of the interrupt controller.
package mic_pkg;

	// Number of arbitrated sources
	localparam int          MIC_NUM_SRC        = 12;
	localparam int          MIC_SRC_W          = 4;

	// Register byte addresses on the APB side
	localparam logic [11:0] MIC_ADDR_EN_MASK   = 12'h0A8;
	localparam logic [11:0] MIC_ADDR_EXT_EN    = 12'h0B0;
	localparam logic [11:0] MIC_ADDR_PRIO      = 12'h0B4;
	localparam logic [11:0] MIC_ADDR_STATUS    = 12'h0B8;

	// Enable register field positions
	localparam int          MIC_EN_GLOBAL      = 7;
	localparam int          MIC_EN_SPARE       = 6;
	localparam int          MIC_EN_TIMER2      = 5;
	localparam int          MIC_EN_SERIAL      = 4;
	localparam int          MIC_EN_TIMER1      = 3;
	localparam int          MIC_EN_EXT1        = 2;
	localparam int          MIC_EN_TIMER0      = 1;
	localparam int          MIC_EN_EXT0        = 0;

	// Status register field positions
	localparam int          MIC_ST_REQ_LSB     = 0;
	localparam int          MIC_ST_INSVC_LO    = 12;
	localparam int          MIC_ST_INSVC_HI    = 13;
	localparam int          MIC_ST_BUSY        = 14;
	localparam int          MIC_ST_SRC_LSB     = 16;

	// Reset values
	localparam logic [7:0]  MIC_EN_MASK_RESET  = 8'h00;
	localparam logic [5:0]  MIC_EXT_EN_RESET   = 6'h00;
	localparam logic [11:0] MIC_PRIO_RESET     = 12'h000;

	// Vector addresses
	localparam logic [15:0] MIC_VEC_RESET      = 16'h0000;
	localparam logic [15:0] MIC_VEC_BASE       = 16'h0003;
	localparam int          MIC_VEC_SHIFT      = 3;

	// Sources whose pending flag hardware clears on vectoring
	localparam logic [11:0] MIC_HW_CLEAR_MASK  = 12'h00F;

	// Timing in system clocks
	localparam logic [2:0]  MIC_CALL_CYCLES    = 3'h4;

	// Raw pending flags from the peripherals
	typedef struct packed {
		logic       ext0_pending;
		logic       timer0_overflow_pending;
		logic       ext1_pending;
		logic       timer1_overflow_pending;
		logic       serial_receive_pending;
		logic       serial_transmit_pending;
		logic       timer2_high_overflow;
		logic       timer2_low_overflow;
		logic       twowire_pending;
		logic       adc_window_pending;
		logic       adc_done_pending;
		logic       pca_counter_pending;
		logic [2:0] pca_module_pending;
		logic       cmp_fall_pending;
		logic       cmp_rise_pending;
	} mic_flags_s;

	// Long call request toward the CPU sequencer
	typedef struct packed {
		logic                 start;
		logic [15:0]          vector;
		logic [MIC_SRC_W-1:0] src;
		logic                 high;
	} mic_call_s;

endpackage : mic_pkg

// >>> core/mic_pick.sv
// Fixed-order picker: lowest requesting index wins.
`timescale 1ns/10ps
`default_nettype none

module mic_pick
	import mic_pkg::*;
#(
	parameter int N = MIC_NUM_SRC,
	parameter int W = MIC_SRC_W
) (
	input  wire logic [N-1:0] req,
	output logic              any,
	output logic [W-1:0]      idx
);

	// Scan from the top down so the lowest index is written last
	// fixed order pick
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = W'(i);
			end
		end
	end

endmodule : mic_pick

`default_nettype wire

// >>> core/mic_intc.sv
// Interrupt controller top: APB registers, arbitration, long call sequencing.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module mic_intc
	import mic_pkg::*;
#(
	parameter int AW = 12
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	input  wire logic [3:0]    pstrb,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire mic_flags_s    flags,
	input  wire logic          instr_done,
	input  wire logic          instr_is_return,
	output mic_call_s          call,
	output logic               call_busy,
	output logic               isr_enter,
	output logic [3:0]         hw_clear
);

	// Call sequencing states
	typedef enum logic [0:0] {
		MIC_IDLE,
		MIC_CALL
	} mic_state_e;

	// Software visible registers
	logic [7:0]            interrupt_enable_mask;
	logic [7:0]            next_interrupt_enable_mask;
	logic [5:0]            ext_enable;
	logic [5:0]            next_ext_enable;
	logic [11:0]           prio;
	logic [11:0]           next_prio;
	logic [31:0]           next_prdata;

	// Detection stage
	logic [11:0]           pend_q;
	logic [11:0]           next_pend_q;

	// Sequencing state
	mic_state_e            state;
	mic_state_e            next_state;
	logic [2:0]            call_cnt;
	logic [2:0]            next_call_cnt;
	logic                  insvc_lo;
	logic                  next_insvc_lo;
	logic                  insvc_hi;
	logic                  next_insvc_hi;
	mic_call_s             next_call;
	logic                  next_isr_enter;
	logic [3:0]            next_hw_clear;

	// Arbitration signals
	logic [11:0]           src_en;
	logic [11:0]           req;
	logic [11:0]           req_hi;
	logic [11:0]           req_lo;
	logic                  any_hi;
	logic                  any_lo;
	logic [MIC_SRC_W-1:0]  idx_hi;
	logic [MIC_SRC_W-1:0]  idx_lo;
	logic                  take;
	logic                  take_hi;
	logic [MIC_SRC_W-1:0]  take_idx;

	// Bus decode
	logic                  setup;
	logic                  access;
	logic                  hit_en_mask;
	logic                  hit_ext;
	logic                  hit_prio;
	logic                  hit_status;
	logic                  mapped;
	logic [31:0]           status_word;

	// APB handshake: zero wait states, read data is latched in setup
	assign setup       = psel && !penable;
	assign access      = psel && penable;
	assign hit_en_mask = (paddr == AW'(MIC_ADDR_EN_MASK));
	assign hit_ext     = (paddr == AW'(MIC_ADDR_EXT_EN));
	assign hit_prio    = (paddr == AW'(MIC_ADDR_PRIO));
	assign hit_status  = (paddr == AW'(MIC_ADDR_STATUS));
	assign mapped      = hit_en_mask || hit_ext || hit_prio || hit_status;
	assign pready      = access;
	// Unmapped addresses and writes to the read-only status answer with an error
	assign pslverr     = access && (!mapped || (pwrite && hit_status));

	// Shared vectors fold paired flags into one request line
	// shared source lines
	always_comb begin
		next_pend_q     = '0;
		next_pend_q[0]  = flags.ext0_pending;
		next_pend_q[1]  = flags.timer0_overflow_pending;
		next_pend_q[2]  = flags.ext1_pending;
		next_pend_q[3]  = flags.timer1_overflow_pending;
		next_pend_q[4]  = flags.serial_receive_pending || flags.serial_transmit_pending;
		next_pend_q[5]  = flags.timer2_high_overflow || flags.timer2_low_overflow;
		next_pend_q[6]  = flags.twowire_pending;
		next_pend_q[7]  = flags.adc_window_pending;
		next_pend_q[8]  = flags.adc_done_pending;
		next_pend_q[9]  = flags.pca_counter_pending || (|flags.pca_module_pending);
		next_pend_q[10] = flags.cmp_fall_pending;
		next_pend_q[11] = flags.cmp_rise_pending;
	end

	// Per-source enable vector; spare flag deliberately not used here
	// per-source enable bits
	assign src_en = {ext_enable,
			interrupt_enable_mask[MIC_EN_TIMER2],
			interrupt_enable_mask[MIC_EN_SERIAL],
			interrupt_enable_mask[MIC_EN_TIMER1],
			interrupt_enable_mask[MIC_EN_EXT1],
			interrupt_enable_mask[MIC_EN_TIMER0],
			interrupt_enable_mask[MIC_EN_EXT0]};

	assign req    = interrupt_enable_mask[MIC_EN_GLOBAL] ? (pend_q & src_en) : 12'h000;
	assign req_hi = req & prio;
	assign req_lo = req & ~prio;

	// One picker per priority level
	mic_pick #(
		.N (MIC_NUM_SRC),
		.W (MIC_SRC_W)
	) u_pick_hi (
		.req (req_hi),
		.any (any_hi),
		.idx (idx_hi)
	);

	mic_pick #(
		.N (MIC_NUM_SRC),
		.W (MIC_SRC_W)
	) u_pick_lo (
		.req (req_lo),
		.any (any_lo),
		.idx (idx_lo)
	);

	// Entry decision, evaluated on every clock from the sampled flags
	// decode each cycle
	always_comb begin
		take     = 1'b0;
		take_hi  = 1'b0;
		take_idx = idx_lo;
		if (insvc_hi) begin
			take = 1'b0;
		end else if (insvc_lo) begin
			take     = any_hi;
			take_hi  = any_hi;
			take_idx = idx_hi;
		end else if (any_hi) begin
			take     = 1'b1;
			take_hi  = 1'b1;
			take_idx = idx_hi;
		end else begin
			take     = any_lo;
		end
		// Only at an ordinary instruction boundary while no call runs
		// no entry on return boundary
		if (state != MIC_IDLE || !instr_done || instr_is_return) begin
			take = 1'b0;
		end
	end

	// Call sequencing, nesting levels and hardware flag clears
	always_comb begin
		next_state     = state;
		next_call_cnt  = call_cnt;
		next_insvc_lo  = insvc_lo;
		next_insvc_hi  = insvc_hi;
		next_call      = call;
		next_call.start = 1'b0;
		next_isr_enter = 1'b0;
		next_hw_clear  = 4'h0;
		unique case (state)
			MIC_IDLE: begin
				// Return pops the innermost level; pending flags re-arbitrate later
				// re-entry after return
				if (instr_done && instr_is_return) begin
					if (insvc_hi) begin
						next_insvc_hi = 1'b0;
					end else begin
						next_insvc_lo = 1'b0;
					end
				end
				if (take) begin
					next_state        = MIC_CALL;
					next_call_cnt     = MIC_CALL_CYCLES;
					next_call.start   = 1'b1;
					next_call.src     = take_idx;
					next_call.high    = take_hi;
					next_call.vector  = 16'(MIC_VEC_BASE + (16'(take_idx) << MIC_VEC_SHIFT));
					next_hw_clear     = MIC_HW_CLEAR_MASK[3:0] & 4'(12'h001 << take_idx);
					if (take_hi) begin
						next_insvc_hi = 1'b1;
					end else begin
						next_insvc_lo = 1'b1;
					end
				end
			end
			MIC_CALL: begin
				// Count the call cycles; the routine starts after the last
				next_call_cnt = 3'(call_cnt - 3'h1);
				if (call_cnt == 3'h1) begin
					next_state     = MIC_IDLE;
					next_isr_enter = 1'b1;
				end
			end
		endcase
	end

	assign call_busy = (state == MIC_CALL);

	// Register writes take effect in the access phase only
	always_comb begin
		next_interrupt_enable_mask = interrupt_enable_mask;
		next_ext_enable            = ext_enable;
		next_prio                  = prio;
		if (access && pwrite && pstrb[0]) begin
			if (hit_en_mask) begin
				next_interrupt_enable_mask = pwdata[7:0];
			end
			if (hit_ext) begin
				next_ext_enable = pwdata[5:0];
			end
		end
		// Priority spans two byte lanes
		if (access && pwrite && hit_prio) begin
			if (pstrb[0]) begin
				next_prio[7:0] = pwdata[7:0];
			end
			if (pstrb[1]) begin
				next_prio[11:8] = pwdata[11:8];
			end
		end
	end

	// Status word shows live requests and nesting state
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[MIC_ST_REQ_LSB +: 12]          = req;
		status_word[MIC_ST_INSVC_LO]               = insvc_lo;
		status_word[MIC_ST_INSVC_HI]               = insvc_hi;
		status_word[MIC_ST_BUSY]                   = call_busy;
		status_word[MIC_ST_SRC_LSB +: MIC_SRC_W]   = call.src;
	end

	// Read mux, captured in setup so prdata comes from a flop
	always_comb begin
		next_prdata = prdata;
		if (setup && !pwrite) begin
			next_prdata = 32'h0000_0000;
			if (hit_en_mask) begin
				next_prdata[7:0] = interrupt_enable_mask;
			end else if (hit_ext) begin
				next_prdata[5:0] = ext_enable;
			end else if (hit_prio) begin
				next_prdata[11:0] = prio;
			end else if (hit_status) begin
				next_prdata = status_word;
			end
		end
	end

	// Register all state; reset points the call vector at the reset entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable_mask <= MIC_EN_MASK_RESET;
			ext_enable            <= MIC_EXT_EN_RESET;
			prio                  <= MIC_PRIO_RESET;
			prdata                <= 32'h0000_0000;
			pend_q                <= 12'h000;
			state                 <= MIC_IDLE;
			call_cnt              <= 3'h0;
			insvc_lo              <= 1'b0;
			insvc_hi              <= 1'b0;
			call                  <= '{start: 1'b0, vector: MIC_VEC_RESET,
						src: '0, high: 1'b0};
			isr_enter             <= 1'b0;
			hw_clear              <= 4'h0;
		end else begin
			interrupt_enable_mask <= next_interrupt_enable_mask;
			ext_enable            <= next_ext_enable;
			prio                  <= next_prio;
			prdata                <= next_prdata;
			pend_q                <= next_pend_q;
			state                 <= next_state;
			call_cnt              <= next_call_cnt;
			insvc_lo              <= next_insvc_lo;
			insvc_hi              <= next_insvc_hi;
			call                  <= next_call;
			isr_enter             <= next_isr_enter;
			hw_clear              <= next_hw_clear;
		end
	end

endmodule : mic_intc

`default_nettype wire

// >>> verification/mic_intc_assertions.sv
// Port checker for the interrupt controller, bound into its top.
`timescale 1ns/10ps
`default_nettype none

module mic_intc_assertions
	import mic_pkg::*;
#(
	parameter int AW = 12
) (
	input wire logic          pclk,
	input wire logic          presetn,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [3:0]    pstrb,
	input wire logic          instr_done,
	input wire logic          instr_is_return,
	input wire mic_call_s     call,
	input wire logic          call_busy,
	input wire logic          isr_enter,
	input wire logic [3:0]    hw_clear
);
	logic [7:0] en_shadow;      // Shadow of the enable register
	logic [7:0] next_en_shadow; // Follows completed lane-0 writes only

	// Shadow next value
	always_comb begin
		next_en_shadow = en_shadow;
		if (psel && penable && pwrite && pstrb[0] && paddr == AW'(MIC_ADDR_EN_MASK)) begin
			next_en_shadow = pwdata[7:0];
		end
	end

	// Shadow register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_shadow <= MIC_EN_MASK_RESET;
		end else begin
			en_shadow <= next_en_shadow;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_call_sequence: assert property (
		call.start |-> call_busy [*4] ##1 (!call_busy && isr_enter))
		else $error("call sequence broken");
	a_enter_after_call: assert property (
		isr_enter |-> $past(call.start, 4))
		else $error("entry without call");
	a_vector_map: assert property (
		call.start |-> call.vector == MIC_VEC_BASE + {9'h000, call.src, 3'h0})
		else $error("wrong vector");
	a_hw_clear: assert property (
		hw_clear == ((call.start && call.src < 4'h4) ? 4'(4'h1 << call.src) : 4'h0))
		else $error("wrong flag clear");
	a_return_no_call: assert property (
		instr_done && instr_is_return |=> !call.start)
		else $error("call at return boundary");
	a_start_cause: assert property (
		call.start |-> $past(instr_done && !instr_is_return && !call_busy))
		else $error("call without boundary");
	a_global_gate: assert property (
		call.start |-> $past(en_shadow[MIC_EN_GLOBAL]))
		else $error("call with global off");
	a_source_mask: assert property (
		call.start && call.src < 4'h6 |-> (($past(en_shadow) >> call.src) & 8'h01) == 8'h01)
		else $error("call from masked source");

	c_last_source: cover property (call.start && call.src == 4'hB);
	c_return: cover property (instr_done && instr_is_return);
	c_high_call: cover property (call.start && call.high);
endmodule : mic_intc_assertions

bind mic_intc mic_intc_assertions #(.AW(AW)) u_chk (.*);

`default_nettype wire

// >>> verification/mic_cpu_model.sv
// Behavioural CPU sequencer giving instruction boundaries.
`timescale 1ns/10ps
`default_nettype none

module mic_cpu_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic call_busy,
	input  wire logic return_req,
	output logic      instr_done,
	output logic      instr_is_return
);
	logic next_done;   // One-cycle instructions, stalled while the call runs
	logic next_return; // A requested return marks the next boundary

	always_comb begin
		next_done = !call_busy;
		next_return = return_req && !call_busy;
	end

	// Boundary flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_done <= 1'b0;
			instr_is_return <= 1'b0;
		end else begin
			instr_done <= next_done;
			instr_is_return <= next_return;
		end
	end
endmodule : mic_cpu_model

`default_nettype wire

// >>> verification/mic_intc_bench.sv
// Self-checking bench for the interrupt controller.
`timescale 1ns/10ps
`default_nettype none

module mic_intc_bench
	import mic_pkg::*;
;
	logic        pclk = 1'b0;     // System clock, 50 MHz
	logic        presetn = 1'b0;  // Held low for four cycles
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic        return_req = 1'b0;
	mic_flags_s  flags = '0;      // Bench plays the peripherals
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        instr_done;
	logic        instr_is_return;
	mic_call_s   call;
	logic        call_busy;
	logic        isr_enter;
	logic [3:0]  hw_clear;
	int          n_mismatch = 0;
	int          total_checks = 0;
	logic [31:0] rd;              // Read data of the last transfer
	logic        rd_err;          // Error answer of the last transfer
	int          k;
	// Flag bit per source; paired vectors use the second flag, the PCA vector a module flag
	int          pos [12] = '{16, 15, 14, 13, 11, 9, 8, 7, 6, 3, 1, 0};

	always #10 pclk = ~pclk;

	mic_intc u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flags(flags), .instr_done(instr_done),
		.instr_is_return(instr_is_return), .call(call), .call_busy(call_busy),
		.isr_enter(isr_enter), .hw_clear(hw_clear));
	mic_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .call_busy(call_busy),
		.return_req(return_req), .instr_done(instr_done),
		.instr_is_return(instr_is_return));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : check

	// One APB transfer; waits for pready however long it takes
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		// Data and error answer are both taken at the access edge
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Edges until a call starts, zero if none within lim
	task automatic wait_call(input int lim, output int n);
		n = 0;
		for (int i = 1; i <= lim && n == 0; i++) begin
			@(posedge pclk);
			#1;
			if (call.start === 1'b1) n = i;
		end
	endtask : wait_call

	// Asks the sequencer model for one return-from-interrupt boundary
	task automatic give_return();
		@(posedge pclk);
		return_req <= 1'b1;
		@(posedge pclk);
		return_req <= 1'b0;
	endtask : give_return

	task automatic t_regs();
		apb(1'b0, MIC_ADDR_EN_MASK, 32'h0);
		check(rd, 32'(MIC_EN_MASK_RESET), "enable reset");
		check(32'(rd_err), 32'h0, "mapped read");
		apb(1'b1, MIC_ADDR_EN_MASK, 32'h41);
		apb(1'b0, MIC_ADDR_EN_MASK, 32'h0);
		check(rd, 32'h41, "spare flag");
		apb(1'b0, 12'h004, 32'h0);
		check(rd, 32'h0, "unmapped data");
		check(32'(rd_err), 32'h1, "unmapped error");
		$display("t_regs done");
	endtask : t_regs

	task automatic t_gate();
		apb(1'b1, MIC_ADDR_EN_MASK, 32'h7F);
		@(posedge pclk) flags <= '1;
		wait_call(20, k);
		check(k, 0, "global off");
		apb(1'b1, MIC_ADDR_EN_MASK, 32'h80);
		wait_call(20, k);
		check(k, 0, "all masked");
		@(posedge pclk) flags <= '0;
		$display("t_gate done");
	endtask : t_gate

	task automatic t_best();
		apb(1'b1, MIC_ADDR_EN_MASK, 32'h81);
		@(posedge pclk) flags <= mic_flags_s'(17'h10000);
		k = 0;
		do begin
			@(posedge pclk);
			#1;
			k++;
		end while (isr_enter !== 1'b1 && k < 20);
		check(k, 6, "best latency");
		check(32'(call.vector), 32'(MIC_VEC_BASE), "vector");
		@(posedge pclk) flags <= '0;
		give_return();
		$display("t_best done");
	endtask : t_best

	task automatic t_order();
		logic [16:0] m;
		apb(1'b1, MIC_ADDR_EN_MASK, 32'hBF);
		apb(1'b1, MIC_ADDR_EXT_EN, 32'h3F);
		for (int i = 0; i < 12; i++) begin
			m = '0;
			for (int j = i; j < 12; j++) m[pos[j]] = 1'b1;
			@(posedge pclk) flags <= mic_flags_s'(m);
			wait_call(10, k);
			// A missing call would leave the previous source standing
			check(k, 2, "order latency");
			check(32'(call.src), i, "fixed order");
			check(32'(call.vector), 32'(MIC_VEC_BASE) + 8 * i, "vector");
			check(32'(hw_clear), (i < 4) ? (32'h1 << i) : 32'h0, "flag clear");
			repeat (6) @(posedge pclk);
			flags <= '0;
			give_return();
			repeat (3) @(posedge pclk);
		end
		$display("t_order done");
	endtask : t_order

	task automatic t_return();
		apb(1'b1, MIC_ADDR_EN_MASK, 32'h90);
		@(posedge pclk) flags <= mic_flags_s'(17'h01000);
		wait_call(10, k);
		wait_call(15, k);
		check(k, 0, "equal level");
		give_return();
		wait_call(10, k);
		check(k, 2, "re-entry");
		repeat (6) @(posedge pclk);
		flags <= '0;
		give_return();
		$display("t_return done");
	endtask : t_return

	task automatic t_preempt();
		// Timer 0 and external 1 high, external 0 low
		apb(1'b1, MIC_ADDR_PRIO, 32'h6);
		apb(1'b0, MIC_ADDR_PRIO, 32'h0);
		check(rd, 32'h6, "priority readback");
		apb(1'b1, MIC_ADDR_EN_MASK, 32'h87);
		@(posedge pclk) flags <= mic_flags_s'(17'h10000);
		wait_call(10, k);
		repeat (6) @(posedge pclk);
		flags <= mic_flags_s'(17'h18000);
		wait_call(10, k);
		check(32'(call.src), 1, "preempt");
		check(32'(call.high), 1, "high level");
		repeat (6) @(posedge pclk);
		// A high request during a high routine must still wait
		flags <= mic_flags_s'(17'h04000);
		wait_call(15, k);
		check(k, 0, "high kept");
		@(posedge pclk) flags <= '0;
		give_return();
		give_return();
		$display("t_preempt done");
	endtask : t_preempt

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_gate();
		t_best();
		t_order();
		t_return();
		t_preempt();
		close_out();
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#(20 * 5000);
		n_mismatch++;
		close_out();
	end
endmodule : mic_intc_bench

`default_nettype wire
